// *** scgc_top.v ***
`include "scgc_map.vh"

module scgc_top (
    // Clock and reset.
    input  wire       i_clk,
    input  wire       i_rst,
    // Register port.
    input  wire [7:0] i_addr,
    input  wire [7:0] i_wdata,
    input  wire       i_we,
    input  wire       i_re,
    output reg  [7:0] o_rdata,
    // Events and straps.
    input  wire       i_periph_irq,
    input  wire       i_crystal_stopped,
    input  wire       i_count_source_protect_init,
    // CPU and peripheral clocking.
    output wire       o_cpu_clk_en,
    output reg        o_periph_clk_on,
    output reg        o_wait_mode,
    output reg        o_stop_mode,
    // Oscillator controls.
    output reg        o_crystal_buf_on,
    output reg        o_feedback_res_on,
    output reg        o_crystal_in_accept,
    output reg        o_port_pins_gpio,
    output reg        o_slow_osc_on,
    output reg        o_fast_osc_on,
    output reg        o_fast_osc_select,
    output reg        o_wdt_osc_on,
    output reg        o_sys_clk_onchip,
    // Oscillation stop interrupt request.
    output reg        o_osc_stop_irq
);

    // The fast oscillator can only ever be halved here; a source above twice the limit is not covered.
    localparam [2:0] FAST_PRE_LOG2 = (`SCGC_FAST_OSC_KHZ > `SCGC_CPU_MAX_KHZ) ? 3'h1 : 3'h0;
    // Whole reset bytes, so that single bits can be picked out by field position.
    localparam [7:0] RST_FIRST     = `SCGC_RST_CTRL_FIRST;
    localparam [7:0] RST_DETECT    = `SCGC_RST_STOP_DET;

    // sys_clock_ctrl_first.
    reg        wait_periph_clk_stop_q;
    reg        crystal_stop_q;
    reg        cpu_div_sel_first_q;
    // sys_clock_ctrl_second.
    reg        all_clock_stop_q;
    reg        feedback_res_off_q;
    reg        pin_osc_switch_q;
    reg        slow_int_osc_stop_q;
    reg  [1:0] cpu_div_field_q;
    // sys_clock_ctrl_third.
    reg        wait_control_q;
    reg        wait_exit_no_div_q;
    reg  [1:0] exit_clock_sel_q;
    // osc_stop_detect_ctrl.
    reg        stop_detect_enable_q;
    reg        stop_detect_irq_enable_q;
    reg        system_clock_select_q;
    reg        crystal_monitor_q;
    // write_protect_reg and fast oscillator control.
    reg        clock_reg_write_unlock_q;
    reg        fast_osc_on_q;
    reg        fast_osc_select_q;
    // Strap capture and event history.
    reg        strap_taken_q;
    reg        cspro_init_q;
    reg        detect_prev_q;

    wire       wr_first;
    wire       wr_second;
    wire       wr_third;
    wire       wr_detect;
    wire       wr_fast;
    wire       wr_protect;
    wire       unlock;
    wire       stop_enter;
    wire       wait_enter;
    wire       wake;
    wire       detect_armed;
    wire       detect_hit;
    wire       cpu_run;
    reg  [2:0] div_log2;
    reg  [7:0] rd_value;

    // Maps the division controls to log2 of the divide ratio.
    function [2:0] div_code;
        input       div8;
        input [1:0] field;
        begin
            if (div8) begin
                div_code = `SCGC_LOG2_DIV8;
            end else begin
                case (field)
                    2'h0:    div_code = 3'h0;
                    2'h1:    div_code = 3'h1;
                    2'h2:    div_code = 3'h2;
                    default: div_code = `SCGC_LOG2_DIV16;
                endcase
            end
        end
    endfunction

    assign unlock     = clock_reg_write_unlock_q;
    assign wr_first   = i_we && unlock && (i_addr == `SCGC_OFF_CTRL_FIRST);
    assign wr_second  = i_we && unlock && (i_addr == `SCGC_OFF_CTRL_SECOND);
    assign wr_third   = i_we && unlock && (i_addr == `SCGC_OFF_CTRL_THIRD);
    assign wr_detect  = i_we && unlock && (i_addr == `SCGC_OFF_STOP_DET);
    assign wr_fast    = i_we && unlock && (i_addr == `SCGC_OFF_FAST_OSC);
    assign wr_protect = i_we && (i_addr == `SCGC_OFF_PROTECT);

    assign stop_enter = wr_second && i_wdata[`SCGC_B_ALL_STOP] && !all_clock_stop_q;
    assign wait_enter = wr_third && i_wdata[`SCGC_B_WAIT_CTRL] && !wait_control_q;
    assign wake       = i_periph_irq && (wait_control_q || all_clock_stop_q);

    assign detect_armed = stop_detect_enable_q && stop_detect_irq_enable_q;
    assign detect_hit   = detect_armed && i_crystal_stopped;

    // CPU clock held in wait and stop
    assign cpu_run = !wait_control_q && !all_clock_stop_q;

    always @* begin
        div_log2 = div_code(cpu_div_sel_first_q, cpu_div_field_q);
        if (system_clock_select_q && fast_osc_select_q) begin
            div_log2 = div_log2 + FAST_PRE_LOG2;
        end
    end

    always @(posedge i_clk) begin
        if (i_rst) begin
            wait_periph_clk_stop_q   <= 1'b0;
            crystal_stop_q           <= RST_FIRST[`SCGC_B_XTAL_STOP];
            cpu_div_sel_first_q      <= RST_FIRST[`SCGC_B_DIV8];
            all_clock_stop_q         <= 1'b0;
            feedback_res_off_q       <= 1'b0;
            pin_osc_switch_q         <= 1'b0;
            slow_int_osc_stop_q      <= 1'b0;
            cpu_div_field_q          <= 2'h0;
            wait_control_q           <= 1'b0;
            wait_exit_no_div_q       <= 1'b0;
            exit_clock_sel_q         <= `SCGC_EXIT_KEEP;
            stop_detect_enable_q     <= 1'b0;
            stop_detect_irq_enable_q <= 1'b0;
            system_clock_select_q    <= RST_DETECT[`SCGC_B_SYS_SEL];
            clock_reg_write_unlock_q <= 1'b0;
            fast_osc_on_q            <= 1'b0;
            fast_osc_select_q        <= 1'b0;
        end else begin
            if (wr_protect) begin
                clock_reg_write_unlock_q <= i_wdata[`SCGC_B_UNLOCK];
            end
            if (wr_first) begin
                wait_periph_clk_stop_q <= i_wdata[`SCGC_B_WAIT_PSTOP];
                crystal_stop_q         <= i_wdata[`SCGC_B_XTAL_STOP];
                cpu_div_sel_first_q    <= i_wdata[`SCGC_B_DIV8];
            end
            if (wr_second) begin
                all_clock_stop_q   <= i_wdata[`SCGC_B_ALL_STOP];
                feedback_res_off_q <= i_wdata[`SCGC_B_FB_OFF];
                pin_osc_switch_q   <= pin_osc_switch_q | i_wdata[`SCGC_B_PIN_SW];
                slow_int_osc_stop_q <= i_wdata[`SCGC_B_SLOW_STOP] & !system_clock_select_q;
                cpu_div_field_q    <= {i_wdata[`SCGC_B_DIVF_HI], i_wdata[`SCGC_B_DIVF_LO]};
            end
            if (wr_third) begin
                wait_control_q     <= i_wdata[`SCGC_B_WAIT_CTRL];
                wait_exit_no_div_q <= i_wdata[`SCGC_B_EXIT_NODIV];
                exit_clock_sel_q   <= {i_wdata[`SCGC_B_EXIT_HI], i_wdata[`SCGC_B_EXIT_LO]};
            end
            if (wr_detect) begin
                stop_detect_enable_q     <= i_wdata[`SCGC_B_DET_EN];
                stop_detect_irq_enable_q <= i_wdata[`SCGC_B_DET_IRQ];
                system_clock_select_q    <= i_wdata[`SCGC_B_SYS_SEL] | crystal_monitor_q;
            end
            if (wr_fast) begin
                fast_osc_on_q     <= i_wdata[`SCGC_B_FAST_ON];
                fast_osc_select_q <= i_wdata[`SCGC_B_FAST_SEL];
            end
            if (stop_enter) begin
                cpu_div_sel_first_q <= 1'b1;
            end
            if (wait_enter && i_wdata[`SCGC_B_EXIT_NODIV]) begin
                cpu_div_sel_first_q <= 1'b0;
                cpu_div_field_q     <= 2'h0;
            end
            if (wake) begin
                wait_control_q   <= 1'b0;
                all_clock_stop_q <= 1'b0;
                case (exit_clock_sel_q)
                    `SCGC_EXIT_FAST: begin
                        system_clock_select_q <= 1'b1;
                        fast_osc_on_q         <= 1'b1;
                        fast_osc_select_q     <= 1'b1;
                    end
                    `SCGC_EXIT_XTAL: begin
                        crystal_stop_q        <= 1'b0;
                        pin_osc_switch_q      <= 1'b1;
                        system_clock_select_q <= 1'b0;
                    end
                    default: begin
                        system_clock_select_q <= system_clock_select_q;
                    end
                endcase
            end
            if (detect_hit) begin
                system_clock_select_q <= 1'b1;
            end
            if (system_clock_select_q) begin
                slow_int_osc_stop_q <= 1'b0;
            end
        end
    end

    // The strap is sampled once, on the first edge after reset is released.
    always @(posedge i_clk) begin
        if (i_rst) begin
            strap_taken_q <= 1'b0;
            cspro_init_q  <= 1'b1;
        end else if (!strap_taken_q) begin
            strap_taken_q <= 1'b1;
            cspro_init_q  <= i_count_source_protect_init;
        end
    end

    // Monitor and interrupt request.
    always @(posedge i_clk) begin
        if (i_rst) begin
            crystal_monitor_q <= 1'b0;
            detect_prev_q     <= 1'b0;
            o_osc_stop_irq    <= 1'b0;
        end else begin
            crystal_monitor_q <= (stop_detect_enable_q | stop_detect_irq_enable_q) & i_crystal_stopped;
            detect_prev_q     <= detect_hit;
            o_osc_stop_irq    <= detect_hit & !detect_prev_q;
        end
    end

    always @* begin
        rd_value = 8'h00;
        case (i_addr)
            `SCGC_OFF_CTRL_FIRST: begin
                rd_value[`SCGC_B_WAIT_PSTOP] = wait_periph_clk_stop_q;
                rd_value[`SCGC_B_XTAL_STOP]  = crystal_stop_q;
                rd_value[`SCGC_B_DIV8]       = cpu_div_sel_first_q;
            end
            `SCGC_OFF_CTRL_SECOND: begin
                rd_value[`SCGC_B_ALL_STOP]  = all_clock_stop_q;
                rd_value[`SCGC_B_FB_OFF]    = feedback_res_off_q;
                rd_value[`SCGC_B_PIN_SW]    = pin_osc_switch_q;
                rd_value[`SCGC_B_SLOW_STOP] = slow_int_osc_stop_q;
                rd_value[`SCGC_B_RSVD_ONE]  = 1'b1;
                rd_value[`SCGC_B_DIVF_LO]   = cpu_div_field_q[0];
                rd_value[`SCGC_B_DIVF_HI]   = cpu_div_field_q[1];
            end
            `SCGC_OFF_CTRL_THIRD: begin
                rd_value[`SCGC_B_WAIT_CTRL]  = wait_control_q;
                rd_value[`SCGC_B_EXIT_NODIV] = wait_exit_no_div_q;
                rd_value[`SCGC_B_EXIT_LO]    = exit_clock_sel_q[0];
                rd_value[`SCGC_B_EXIT_HI]    = exit_clock_sel_q[1];
            end
            `SCGC_OFF_STOP_DET: begin
                rd_value[`SCGC_B_DET_EN]  = stop_detect_enable_q;
                rd_value[`SCGC_B_DET_IRQ] = stop_detect_irq_enable_q;
                rd_value[`SCGC_B_SYS_SEL] = system_clock_select_q;
                rd_value[`SCGC_B_MONITOR] = crystal_monitor_q;
            end
            `SCGC_OFF_PROTECT: begin
                rd_value[`SCGC_B_UNLOCK] = clock_reg_write_unlock_q;
            end
            `SCGC_OFF_FAST_OSC: begin
                rd_value[`SCGC_B_FAST_ON]  = fast_osc_on_q;
                rd_value[`SCGC_B_FAST_SEL] = fast_osc_select_q;
            end
            default: begin
                rd_value = 8'h00;
            end
        endcase
    end

    // Outputs are registered, so every pin lags its control bit by one cycle.
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_rdata             <= 8'h00;
            o_periph_clk_on     <= 1'b1;
            o_wait_mode         <= 1'b0;
            o_stop_mode         <= 1'b0;
            o_crystal_buf_on    <= 1'b0;
            o_feedback_res_on   <= 1'b1;
            o_crystal_in_accept <= 1'b0;
            o_port_pins_gpio    <= 1'b1;
            o_slow_osc_on       <= 1'b1;
            o_fast_osc_on       <= 1'b0;
            o_fast_osc_select   <= 1'b0;
            o_wdt_osc_on        <= 1'b0;
            o_sys_clk_onchip    <= 1'b1;
        end else begin
            if (i_re) begin
                o_rdata <= rd_value;
            end
            o_periph_clk_on     <= !all_clock_stop_q && !(wait_control_q && wait_periph_clk_stop_q);
            o_wait_mode         <= wait_control_q;
            o_stop_mode         <= all_clock_stop_q;
            o_crystal_buf_on    <= !crystal_stop_q && !all_clock_stop_q && pin_osc_switch_q;
            o_crystal_in_accept <= pin_osc_switch_q;
            o_feedback_res_on   <= !feedback_res_off_q && !all_clock_stop_q && pin_osc_switch_q;
            o_port_pins_gpio    <= crystal_stop_q && !pin_osc_switch_q;
            o_slow_osc_on       <= !slow_int_osc_stop_q && !all_clock_stop_q;
            o_fast_osc_on       <= fast_osc_on_q && !all_clock_stop_q;
            o_fast_osc_select   <= fast_osc_select_q;
            o_wdt_osc_on        <= strap_taken_q && !cspro_init_q;
            o_sys_clk_onchip    <= system_clock_select_q;
        end
    end

    scgc_div #(
        .CNT_W (5)
    ) u_cpu_div (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .i_run  (cpu_run),
        .i_log2 (div_log2),
        .o_tick (o_cpu_clk_en)
    );

endmodule // scgc_top

// *** scgc_map.vh ***
`ifndef SCGC_MAP_VH
`define SCGC_MAP_VH

// Register byte offsets on the 8-bit register port.
`define SCGC_OFF_CTRL_FIRST   8'h06
`define SCGC_OFF_CTRL_SECOND  8'h07
`define SCGC_OFF_CTRL_THIRD   8'h09
`define SCGC_OFF_PROTECT      8'h0a
`define SCGC_OFF_STOP_DET     8'h0c
`define SCGC_OFF_FAST_OSC     8'h23

// Reset values.
`define SCGC_RST_CTRL_FIRST   8'h60
`define SCGC_RST_CTRL_SECOND  8'h20
`define SCGC_RST_CTRL_THIRD   8'h00
`define SCGC_RST_STOP_DET     8'h04
`define SCGC_RST_PROTECT      8'h00
`define SCGC_RST_FAST_OSC     8'h00

// sys_clock_ctrl_first fields.
`define SCGC_B_WAIT_PSTOP     2
`define SCGC_B_XTAL_STOP      5
`define SCGC_B_DIV8           6
// sys_clock_ctrl_second fields.
`define SCGC_B_ALL_STOP       0
`define SCGC_B_FB_OFF         1
`define SCGC_B_PIN_SW         3
`define SCGC_B_SLOW_STOP      4
`define SCGC_B_RSVD_ONE       5
`define SCGC_B_DIVF_LO        6
`define SCGC_B_DIVF_HI        7
// sys_clock_ctrl_third fields.
`define SCGC_B_WAIT_CTRL      0
`define SCGC_B_EXIT_NODIV     5
`define SCGC_B_EXIT_LO        6
`define SCGC_B_EXIT_HI        7
// osc_stop_detect_ctrl fields.
`define SCGC_B_DET_EN         0
`define SCGC_B_DET_IRQ        1
`define SCGC_B_SYS_SEL        2
`define SCGC_B_MONITOR        3
// write_protect_reg and fast oscillator control fields.
`define SCGC_B_UNLOCK         0
`define SCGC_B_FAST_ON        0
`define SCGC_B_FAST_SEL       1

// Exit clock selections.
`define SCGC_EXIT_KEEP        2'h0
`define SCGC_EXIT_FAST        2'h2
`define SCGC_EXIT_XTAL        2'h3

// Division as log2 of the ratio.
`define SCGC_LOG2_DIV8        3'h3
`define SCGC_LOG2_DIV16       3'h4

// Oscillator and CPU clock limits in kHz.
`define SCGC_FAST_OSC_KHZ     40000
`define SCGC_CPU_MAX_KHZ      20000

`endif

// *** scgc_div.v ***
// Clock-enable divider: one tick every 2**i_log2 cycles while running, for i_log2 up to CNT_W; above that the period stays 2**CNT_W.
module scgc_div #(
    parameter CNT_W = 5
) (
    // Clock and reset.
    input  wire             i_clk,
    input  wire             i_rst,
    // Control.
    input  wire             i_run,
    input  wire [2:0]       i_log2,
    // Enable pulse.
    output reg              o_tick
);

    reg  [CNT_W-1:0] cnt_q;
    wire [CNT_W:0]   span;
    wire [CNT_W-1:0] limit;

    assign span  = {{CNT_W{1'b0}}, 1'b1} << i_log2;
    // A span of exactly 2**CNT_W wraps to zero and the decrement yields all ones.
    assign limit = span[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};

    always @(posedge i_clk) begin
        if (i_rst || !i_run) begin
            cnt_q  <= {CNT_W{1'b0}};
            o_tick <= 1'b0;
        end else if (cnt_q >= limit) begin
            cnt_q  <= {CNT_W{1'b0}};
            o_tick <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
            o_tick <= 1'b0;
        end
    end

endmodule // scgc_div

// *** scgc_props.sv ***
module scgc_props (
    input wire       i_clk,
    input wire       i_rst,
    input wire       i_periph_irq,
    input wire       i_crystal_stopped,
    input wire       o_cpu_clk_en,
    input wire       o_wait_mode,
    input wire       o_stop_mode,
    input wire       o_crystal_buf_on,
    input wire       o_feedback_res_on,
    input wire       o_crystal_in_accept,
    input wire       o_port_pins_gpio,
    input wire       o_slow_osc_on,
    input wire       o_sys_clk_onchip,
    input wire       o_osc_stop_irq
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    pin_switch_sticky_a: assert property (
        o_crystal_in_accept |=> o_crystal_in_accept) else $error("pin switch cleared");
    pins_released_a: assert property (
        o_port_pins_gpio |-> !o_crystal_in_accept && !o_crystal_buf_on) else $error("port pins clash");
    stop_resistor_off_a: assert property (
        o_stop_mode |-> !o_feedback_res_on) else $error("resistor on in stop");
    slow_osc_forced_a: assert property (
        o_sys_clk_onchip [*2] |-> o_slow_osc_on || o_stop_mode) else $error("slow osc off on chip clock");
    stop_irq_pulse_a: assert property (
        o_osc_stop_irq |=> !o_osc_stop_irq) else $error("irq longer than one cycle");
    stop_irq_cause_a: assert property (
        o_osc_stop_irq |-> $past(i_crystal_stopped) ##1 o_sys_clk_onchip) else $error("irq without cause");
    cpu_clock_halt_a: assert property (
        o_wait_mode || o_stop_mode |-> !o_cpu_clk_en) else $error("cpu clock in low power");
    wake_exit_a: assert property (
        (o_wait_mode || o_stop_mode) && i_periph_irq |-> ##2 !o_wait_mode && !o_stop_mode)
        else $error("no wake on irq");

    cover property (o_osc_stop_irq);
    cover property (o_wait_mode && i_periph_irq);
    cover property (o_stop_mode && i_periph_irq);
endmodule // scgc_props

bind scgc_top scgc_props u_props (.*);

// *** scgc_xtal_model.sv ***
module scgc_xtal_model (
    input  wire  i_clk,
    input  wire  i_buf_on,
    input  wire  i_pins_osc,
    input  wire  i_ext_clk,
    input  wire  i_fail,
    output logic o_stopped
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] start_q = 4'h0;
    // external clock accepted
    // The resonator needs some cycles to build up, so a new start is never instant.
    always @(posedge i_clk) begin
        if (i_fail || !(i_buf_on || (i_ext_clk && i_pins_osc)))
            start_q <= 4'h0;
        else if (start_q != 4'hf)
            start_q <= start_q + 4'h1;
    end
    assign o_stopped = (start_q != 4'hf);
endmodule // scgc_xtal_model

// *** scgc_top_tb.sv ***
module scgc_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic       i_clk = 1'b0;
    logic       i_rst = 1'b1;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic       i_we = 1'b0;
    logic       i_re = 1'b0;
    logic       i_periph_irq = 1'b0;
    logic       i_count_source_protect_init = 1'b0;
    logic       fail = 1'b0;
    logic       ext_clk = 1'b0;
    logic       re_q = 1'b0;
    logic [15:0] rnd;
    logic [7:0] expq[$];
    logic [7:0] ra[6] = '{8'h06, 8'h07, 8'h09, 8'h0c, 8'h0a, 8'h01};
    logic [7:0] rv[6] = '{8'h60, 8'h20, 8'h00, 8'h04, 8'h00, 8'h00};
    logic [7:0] pt[4] = '{8'h01, 8'h02, 8'h04, 8'h10};
    int         n_fail = 0;
    int         checks_done = 0;
    int         cycles = 0;
    int         n;
    wire [7:0]  o_rdata;
    wire        i_crystal_stopped, o_cpu_clk_en, o_periph_clk_on, o_wait_mode, o_stop_mode;
    wire        o_crystal_buf_on, o_feedback_res_on, o_crystal_in_accept, o_port_pins_gpio;
    wire        o_slow_osc_on, o_fast_osc_on, o_fast_osc_select, o_wdt_osc_on;
    wire        o_sys_clk_onchip, o_osc_stop_irq;

    scgc_top u_dut (.*);
    scgc_xtal_model u_xtal (.i_clk(i_clk), .i_buf_on(o_crystal_buf_on), .i_pins_osc(o_crystal_in_accept),
        .i_ext_clk(ext_clk), .i_fail(fail), .o_stopped(i_crystal_stopped));

    always #10 i_clk = ~i_clk;

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        i_we = 1'b1;
        i_addr = a;
        i_wdata = d;
        @(negedge i_clk);
        i_we = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge i_clk);
        i_re = 1'b1;
        i_addr = a;
        expq.push_back(e);
        @(negedge i_clk);
        i_re = 1'b0;
    endtask

    task automatic irq_pulse;
        @(negedge i_clk);
        i_periph_irq = 1'b1;
        @(negedge i_clk);
        i_periph_irq = 1'b0;
        repeat (2) @(negedge i_clk);
    endtask

    // Waits 40 cycles and then for a tick first, since a divider change may leave one odd gap.
    task automatic per(input logic [7:0] e);
        logic [7:0] c;
        repeat (40) @(negedge i_clk);
        for (c = 8'h0; o_cpu_clk_en !== 1'b1 && c < 8'h40; c++)
            @(negedge i_clk);
        for (c = 8'h1; c < 8'h40; c++) begin
            @(negedge i_clk);
            if (o_cpu_clk_en === 1'b1)
                break;
        end
        chk(c, e);
    endtask

    always @(posedge i_clk) begin
        re_q <= i_re;
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            report_and_stop;
        end
    end

    always @(negedge i_clk) begin
        if (re_q)
            chk(o_rdata, expq.pop_front());
    end

    initial begin
        rnd = lfsr(16'hc245);
        i_count_source_protect_init = rnd[0];
        repeat (10) @(negedge i_clk);
        i_rst = 1'b0;
        repeat (2) @(negedge i_clk);
        chk({7'h0, o_wdt_osc_on}, {7'h0, ~rnd[0]});
        chk({4'h0, o_slow_osc_on, o_fast_osc_on, o_crystal_buf_on, o_port_pins_gpio}, 8'h09);
        foreach (ra[i]) rd(ra[i], rv[i]);
        rnd = lfsr(rnd);
        wr(8'h07, rnd[15:8]);
        rd(8'h07, 8'h20);
        $display("test reset and lock done");
        wr(8'h0a, 8'h01);
        wr(8'h06, 8'h20);
        for (int f = 0; f < 4; f++) begin
            wr(8'h07, {f[1:0], 6'h20});
            per(pt[f]);
        end
        wr(8'h06, 8'h60);
        per(8'h08);
        wr(8'h07, 8'h30);
        rd(8'h07, 8'h20);
        wr(8'h07, 8'h28);
        wr(8'h07, 8'h20);
        rd(8'h07, 8'h28);
        chk({6'h0, o_port_pins_gpio, o_crystal_in_accept}, 8'h01);
        $display("test divider and pins done");
        wr(8'h06, 8'h40);
        repeat (20) @(negedge i_clk);
        chk({6'h0, o_crystal_buf_on, o_feedback_res_on}, 8'h03);
        wr(8'h0c, 8'h03);
        rd(8'h0c, 8'h03);
        fail = 1'b1;
        for (n = 0; o_osc_stop_irq !== 1'b1 && n < 10; n++)
            @(negedge i_clk);
        chk({7'h0, o_osc_stop_irq}, 8'h01);
        @(negedge i_clk);
        chk({6'h0, o_osc_stop_irq, o_sys_clk_onchip}, 8'h01);
        wr(8'h0c, 8'h03);
        rd(8'h0c, 8'h0f);
        wr(8'h0c, 8'h04);
        rd(8'h0c, 8'h04);
        wr(8'h06, 8'h60);
        fail = 1'b0;
        $display("test stop detection done");
        wr(8'h06, 8'h64);
        wr(8'h07, 8'he8);
        wr(8'h09, 8'ha1);
        repeat (2) @(negedge i_clk);
        chk({6'h0, o_wait_mode, o_periph_clk_on}, 8'h02);
        irq_pulse;
        chk({4'h0, o_wait_mode, o_fast_osc_on, o_fast_osc_select, o_sys_clk_onchip}, 8'h07);
        rd(8'h09, 8'ha0);
        rd(8'h06, 8'h24);
        rd(8'h07, 8'h28);
        per(8'h02);
        $display("test wait mode done");
        wr(8'h09, 8'hc0);
        wr(8'h07, 8'h29);
        repeat (2) @(negedge i_clk);
        chk({6'h0, o_stop_mode, o_feedback_res_on}, 8'h02);
        rd(8'h06, 8'h64);
        irq_pulse;
        rd(8'h06, 8'h44);
        rd(8'h07, 8'h28);
        rd(8'h0c, 8'h00);
        $display("test stop mode done");
        ext_clk = 1'b1;
        wr(8'h07, 8'h2a);
        wr(8'h06, 8'h60);
        repeat (20) @(negedge i_clk);
        chk({5'h0, o_crystal_buf_on, o_feedback_res_on, o_crystal_in_accept}, 8'h01);
        wr(8'h0c, 8'h01);
        rd(8'h0c, 8'h01);
        $display("test external clock done");
        report_and_stop;
    end
endmodule // scgc_top_tb
